// ==== hw/dcc_top.sv ====
// Dual comparator control and status logic with an AXI4-Lite slave
`timescale 1ns/1ps
`include "dcc_defines.svh"

// Operation
// - Control bit 7 powers its comparator on when set, off when cleared.
// - Control bit 6 drives the polarised result onto the result pin while bit 7 is set.
// - Bit 5 inverts result before status bit, pin output and edge detection.
// - Edge select: 11 any change, 10 falling, 01 rising, 00 none.
// - Writing edge select 11 sets the event flag; software clears it.
// - Bit 2 picks ladder reference for plus input, else pin A input.
// - Minus select: 11 bandgap, 10 second B, 01 own C, 00 first B.
// - Status bit 7 shows result two, bit 6 result one, read-only.
// - Status reads 1 when plus exceeds minus, reversed when inverted.
// - Status bits 4 to 0 always read zero.
// - Raw comparator output is high when plus input is above minus.
// - Edge select 00 keeps the event flag clear whatever the output does.
// - Writing 1 sets a flag as simulated event; flags stay set until cleared.
module dcc_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite write address
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output dcc_pkg::dcc_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read address
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output dcc_pkg::dcc_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Analog comparators, index 0 is comparator one
    input logic [1:0] cmp_raw,
    output logic [1:0] cmp_on,
    output logic [1:0] plus_input_select,
    output logic [1:0] minus_input_select_one,
    output logic [1:0] minus_input_select_two,
    // Result pins
    output logic [1:0] result_pin,
    output logic [1:0] result_pin_oe,
    // Interrupt
    output logic irq
);
    import dcc_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic dcc_sel_t addr_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] lo;
        lo = a[7:0];
        // A shift keeps this legal when the address is only eight bits wide
        if ((a >> 8) != '0)
            return DCC_SEL_NONE;
        case (lo)
            `DCC_OFF_CTRL_ONE: return DCC_SEL_CTRL_ONE;
            `DCC_OFF_CTRL_TWO: return DCC_SEL_CTRL_TWO;
            `DCC_OFF_RESULT: return DCC_SEL_RESULT;
            `DCC_OFF_FLAG: return DCC_SEL_FLAG;
            `DCC_OFF_FLAG_CLR: return DCC_SEL_FLAG_CLR;
            `DCC_OFF_FLAG_EN: return DCC_SEL_FLAG_EN;
            `DCC_OFF_FLAG_SET: return DCC_SEL_FLAG_SET;
            default: return DCC_SEL_NONE;
        endcase
    endfunction

    function automatic logic edge_hit(input dcc_edge_t mode,
                                      input logic was, input logic now);
        case (mode)
            DCC_EDGE_RISE: return ~was & now;
            DCC_EDGE_FALL: return was & ~now;
            DCC_EDGE_ANY: return was ^ now;
            default: return 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r [2];
    logic [1:0] sync1_r, sync2_r, res_r, prev_r, flag_r, flag_en_r;
    logic [1:0] evt, flag_set, flag_clr;
    logic aw_held_r, w_held_r, wr_go, wr_lane_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [7:0] wdata_r;
    dcc_sel_t wsel, rsel;
    logic [31:0] rd_mux;

    assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign wsel = addr_sel(waddr_r);
    assign rsel = addr_sel(s_axi_araddr);

    // ----------------------------------------------------------------
    // Write channels: address and data taken in either order
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held_r <= 1'b0;
            waddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
        end else begin
            if (wr_go)
                aw_held_r <= 1'b0;
            s_axi_awready <= ~aw_held_r & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held_r <= 1'b0;
            wdata_r <= 8'h00;
            wr_lane_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wr_lane_r <= s_axi_wstrb[0];
        end else begin
            if (wr_go)
                w_held_r <= 1'b0;
            s_axi_wready <= ~w_held_r & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DCC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == DCC_SEL_NONE) ? DCC_RESP_SLVERR
                                                  : DCC_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r[0] <= `DCC_CTRL_RST;
            ctrl_r[1] <= `DCC_CTRL_RST;
        end else if (wr_go && wr_lane_r) begin
            if (wsel == DCC_SEL_CTRL_ONE)
                ctrl_r[0] <= wdata_r;
            if (wsel == DCC_SEL_CTRL_TWO)
                ctrl_r[1] <= wdata_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            flag_en_r <= `DCC_FLAG_EN_RST;
        else if (wr_go && wr_lane_r && wsel == DCC_SEL_FLAG_EN)
            flag_en_r <= wdata_r[1:0];
    end

    // ----------------------------------------------------------------
    // Result path: the raw outputs are asynchronous to aclk
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end else begin
            sync1_r <= cmp_raw;
            sync2_r <= sync1_r;
        end
    end

    // A powered-down comparator output is meaningless, so it is forced low before the invert bit is applied
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_r <= 2'h0;
            prev_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                res_r[i] <= (sync2_r[i] & ctrl_r[i][`DCC_ON_BIT])
                            ^ ctrl_r[i][`DCC_INV_BIT];
            end
            prev_r <= res_r;
        end
    end

    // ----------------------------------------------------------------
    // Event flags: hardware set wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            evt[i] = ctrl_r[i][`DCC_ON_BIT]
                     & edge_hit(dcc_edge_t'(ctrl_r[i][4:3]),
                                prev_r[i], res_r[i]);
            flag_set[i] = evt[i]
                | (wr_go && wr_lane_r && wsel == DCC_SEL_FLAG_SET
                   && wdata_r[i])
                | (wr_go && wr_lane_r
                   && wsel == ((i == 0) ? DCC_SEL_CTRL_ONE : DCC_SEL_CTRL_TWO)
                   && wdata_r[`DCC_EDGE_HI:`DCC_EDGE_LO] == DCC_EDGE_ANY);
            flag_clr[i] = wr_go && wr_lane_r && wsel == DCC_SEL_FLAG_CLR
                          && wdata_r[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            flag_r <= `DCC_FLAG_RST;
        else
            flag_r <= flag_set | (flag_r & ~flag_clr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(flag_r & flag_en_r);
    end

    // ----------------------------------------------------------------
    // Analog and pin controls
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_on[i] = ctrl_r[i][`DCC_ON_BIT];
            plus_input_select[i] = ctrl_r[i][`DCC_PLUS_BIT];
        end
        minus_input_select_one = ctrl_r[0][1:0];
        minus_input_select_two = ctrl_r[1][1:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_pin <= 2'h0;
            result_pin_oe <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                result_pin[i] <= res_r[i];
                result_pin_oe[i] <= ctrl_r[i][`DCC_ON_BIT]
                                    & ctrl_r[i][`DCC_PIN_OE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (rsel)
            DCC_SEL_CTRL_ONE: rd_mux[7:0] = ctrl_r[0];
            DCC_SEL_CTRL_TWO: rd_mux[7:0] = ctrl_r[1];
            DCC_SEL_RESULT: begin
                rd_mux[`DCC_RES_TWO_BIT] = res_r[1];
                rd_mux[`DCC_RES_ONE_BIT] = res_r[0];
            end
            DCC_SEL_FLAG: rd_mux[1:0] = flag_r;
            DCC_SEL_FLAG_EN: rd_mux[1:0] = flag_en_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= DCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (rsel == DCC_SEL_NONE) ? DCC_RESP_SLVERR
                                                  : DCC_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_res_r;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_res_r <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            rd_res_r <= (rsel == DCC_SEL_RESULT);
    end

    sequence seq_any_write;
        wr_go && wr_lane_r && wsel == DCC_SEL_CTRL_ONE
        && wdata_r[4:3] == DCC_EDGE_ANY;
    endsequence

    sequence seq_rise_seen;
        ctrl_r[0][`DCC_ON_BIT] && ctrl_r[0][4:3] == DCC_EDGE_RISE
        && !prev_r[0] && res_r[0];
    endsequence

    chk_any_sets_flag: assert property (
        seq_any_write |=> flag_r[0])
        else $error("any-change select did not set flag one");

    chk_rise_sets_flag: assert property (
        seq_rise_seen |=> flag_r[0])
        else $error("rising edge did not set flag one");

    chk_off_keeps_clear: assert property (
        (!flag_r[0] && ctrl_r[0][4:3] == DCC_EDGE_OFF && !wr_go)
        |=> !flag_r[0])
        else $error("flag one set with edge select off");

    chk_flag_sticky: assert property (
        (flag_r[1] && !flag_clr[1]) |=> flag_r[1])
        else $error("flag two dropped without a clear");

    chk_result_invert: assert property (
        ##1 res_r[1] == ($past(sync2_r[1] & ctrl_r[1][`DCC_ON_BIT])
                        ^ $past(ctrl_r[1][`DCC_INV_BIT])))
        else $error("result two polarity wrong");

    chk_pin_gating: assert property (
        !ctrl_r[0][`DCC_ON_BIT] [*2] |-> !result_pin_oe[0])
        else $error("disabled comparator drives its pin");

    chk_status_zeros: assert property (
        (s_axi_rvalid && rd_res_r) |-> s_axi_rdata[5:0] == 6'h00)
        else $error("status low bits not zero");

    chk_status_bits: assert property (
        (s_axi_arvalid && s_axi_arready && rsel == DCC_SEL_RESULT)
        |=> s_axi_rdata[7:6] == $past({res_r[1], res_r[0]}))
        else $error("status bits do not show results");

    chk_irq_level: assert property (
        (flag_r[0] && flag_en_r[0]) [*2] |-> irq)
        else $error("enabled flag did not raise irq");

    chk_bvalid_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before bready");

endmodule // dcc_top

// ==== hw/dcc_defines.svh ====
// Register offsets, field positions, reset values of the comparator control
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DCC_OFF_CTRL_ONE 8'h00
`define DCC_OFF_CTRL_TWO 8'h04
`define DCC_OFF_RESULT 8'h08
`define DCC_OFF_FLAG 8'h0c
`define DCC_OFF_FLAG_CLR 8'h10
`define DCC_OFF_FLAG_EN 8'h14
`define DCC_OFF_FLAG_SET 8'h18

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define DCC_ON_BIT 7
`define DCC_PIN_OE_BIT 6
`define DCC_INV_BIT 5
`define DCC_EDGE_HI 4
`define DCC_EDGE_LO 3
`define DCC_PLUS_BIT 2
`define DCC_MINUS_HI 1
`define DCC_MINUS_LO 0

// ----------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------
`define DCC_RES_TWO_BIT 7
`define DCC_RES_ONE_BIT 6
`define DCC_CTRL_RST 8'h1f
`define DCC_FLAG_RST 2'h0
`define DCC_FLAG_EN_RST 2'h0

`endif

// ==== hw/dcc_pkg.sv ====
// Types shared by the dual comparator control block
package dcc_pkg;
    typedef enum logic [1:0] {
        DCC_EDGE_OFF = 2'h0,
        DCC_EDGE_RISE = 2'h1,
        DCC_EDGE_FALL = 2'h2,
        DCC_EDGE_ANY = 2'h3
    } dcc_edge_t;

    typedef enum logic [1:0] {
        DCC_RESP_OKAY = 2'h0,
        DCC_RESP_SLVERR = 2'h2
    } dcc_resp_t;

    typedef enum logic [2:0] {
        DCC_SEL_CTRL_ONE = 3'h0,
        DCC_SEL_CTRL_TWO = 3'h1,
        DCC_SEL_RESULT = 3'h2,
        DCC_SEL_FLAG = 3'h3,
        DCC_SEL_FLAG_CLR = 3'h4,
        DCC_SEL_FLAG_EN = 3'h5,
        DCC_SEL_FLAG_SET = 3'h6,
        DCC_SEL_NONE = 3'h7
    } dcc_sel_t;
endpackage

// ==== tb/test_dual_comparator_control.sv ====
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`include "dcc_defines.svh"

module test_dual_comparator_control;
    import dcc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    dcc_resp_t bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    dcc_resp_t rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [1:0] cmp_raw = 2'b00;
    logic [1:0] cmp_on;
    logic [1:0] plus_sel;
    logic [1:0] minus_one;
    logic [1:0] minus_two;
    logic [1:0] result_pin;
    logic [1:0] result_pin_oe;
    logic irq;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // Whole run is a few hundred cycles; this leaves ample margin
    localparam int LIMIT = 20000;

    always #2 aclk = ~aclk;

    dcc_top #(.ADDR_W(8)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmp_raw(cmp_raw), .cmp_on(cmp_on), .plus_input_select(plus_sel),
        .minus_input_select_one(minus_one),
        .minus_input_select_two(minus_two),
        .result_pin(result_pin), .result_pin_oe(result_pin_oe), .irq(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, input dcc_resp_t er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input dcc_resp_t er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h0, exp});
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // Synchroniser, result and flag stages settle well within six edges
    task automatic set_raw(input logic [1:0] v);
        @(posedge aclk);
        cmp_raw <= v;
        repeat (6) @(posedge aclk);
    endtask

    task automatic clr_flags;
        wr(`DCC_OFF_FLAG_CLR, 8'h03, 4'hf, DCC_RESP_OKAY);
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            finish_test;
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [1:0] k;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`DCC_OFF_CTRL_ONE, 8'h1f, DCC_RESP_OKAY);
        rd(`DCC_OFF_CTRL_TWO, 8'h1f, DCC_RESP_OKAY);
        rd(`DCC_OFF_RESULT, 8'h00, DCC_RESP_OKAY);
        rd(`DCC_OFF_FLAG, 8'h00, DCC_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        chk({30'h0, result_pin_oe}, 32'h0);
        chk({30'h0, minus_one}, 32'h3);
        chk({30'h0, plus_sel}, 32'h3);
        // Unmapped place and a write with no byte lane enabled
        wr(8'h1c, 8'hff, 4'hf, DCC_RESP_SLVERR);
        rd(8'h1c, 8'h00, DCC_RESP_SLVERR);
        wr(`DCC_OFF_CTRL_ONE, 8'h00, 4'h0, DCC_RESP_OKAY);
        rd(`DCC_OFF_CTRL_ONE, 8'h1f, DCC_RESP_OKAY);
        // Status, polarity and pin path
        set_raw(2'b11);
        wr(`DCC_OFF_CTRL_ONE, 8'hc0, 4'hf, DCC_RESP_OKAY);
        wr(`DCC_OFF_CTRL_TWO, 8'ha0, 4'hf, DCC_RESP_OKAY);
        rd(`DCC_OFF_RESULT, 8'h40, DCC_RESP_OKAY);
        chk({30'h0, cmp_on}, 32'h3);
        chk({30'h0, result_pin_oe}, 32'h1);
        chk({31'h0, result_pin[0]}, 32'h1);
        wr(`DCC_OFF_RESULT, 8'hff, 4'hf, DCC_RESP_OKAY);
        rd(`DCC_OFF_RESULT, 8'h40, DCC_RESP_OKAY);
        set_raw(2'b00);
        rd(`DCC_OFF_RESULT, 8'h80, DCC_RESP_OKAY);
        chk({30'h0, result_pin}, 32'h2);
        chk({30'h0, minus_one}, 32'h0);
        chk({31'h0, plus_sel[0]}, 32'h0);
        // Input source selects on comparator two
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            wr(`DCC_OFF_CTRL_TWO, {5'b10000, k[0], k}, 4'hf, DCC_RESP_OKAY);
            rd(`DCC_OFF_CTRL_TWO, {5'b10000, k[0], k}, DCC_RESP_OKAY);
            chk({30'h0, minus_two}, {30'h0, k});
            chk({31'h0, plus_sel[1]}, {31'h0, k[0]});
        end
        // Every edge mode on comparator one, powered on and not inverted
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            clr_flags();
            wr(`DCC_OFF_CTRL_ONE, {3'b100, k, 3'b000}, 4'hf, DCC_RESP_OKAY);
            rd(`DCC_OFF_FLAG, {7'h0, k == 2'b11}, DCC_RESP_OKAY);
            clr_flags();
            set_raw(2'b01);
            rd(`DCC_OFF_FLAG, {7'h0, k[0]}, DCC_RESP_OKAY);
            clr_flags();
            set_raw(2'b00);
            rd(`DCC_OFF_FLAG, {7'h0, k[1]}, DCC_RESP_OKAY);
        end
        // Inverted output: a rising input is a falling event
        clr_flags();
        wr(`DCC_OFF_CTRL_ONE, 8'hb0, 4'hf, DCC_RESP_OKAY);
        clr_flags();
        set_raw(2'b01);
        rd(`DCC_OFF_FLAG, 8'h01, DCC_RESP_OKAY);
        // Disabled comparator with any-change select and pin enable
        set_raw(2'b00);
        wr(`DCC_OFF_CTRL_ONE, 8'h58, 4'hf, DCC_RESP_OKAY);
        clr_flags();
        set_raw(2'b01);
        rd(`DCC_OFF_FLAG, 8'h00, DCC_RESP_OKAY);
        chk({31'h0, result_pin_oe[0]}, 32'h0);
        chk({31'h0, cmp_on[0]}, 32'h0);
        // Software-raised flag, mask and clear
        clr_flags();
        wr(`DCC_OFF_FLAG_EN, 8'h01, 4'hf, DCC_RESP_OKAY);
        rd(`DCC_OFF_FLAG_EN, 8'h01, DCC_RESP_OKAY);
        wr(`DCC_OFF_FLAG_SET, 8'h02, 4'hf, DCC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(`DCC_OFF_FLAG_SET, 8'h01, 4'hf, DCC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`DCC_OFF_FLAG_EN, 8'h00, 4'hf, DCC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(`DCC_OFF_FLAG, 8'h03, DCC_RESP_OKAY);
        wr(`DCC_OFF_FLAG_EN, 8'h03, 4'hf, DCC_RESP_OKAY);
        clr_flags();
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(`DCC_OFF_FLAG, 8'h00, DCC_RESP_OKAY);
        finish_test();
    end
endmodule // test_dual_comparator_control
